// ==== ibs_pkg.sv ====
// shared constants, state enumeration and state record of the isa bus interface
package ibs_pkg;
  // clock and base timing tick
  localparam int CLK_PERIOD_NS = 10;
  localparam int BASE_PERIOD_NS = 50;
  localparam int TICK_DIV = BASE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int DIV_W = 3;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);

  // phase lengths in base ticks
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] ROM_CS_TICKS = 4'h3;
  localparam logic [CNT_W-1:0] SETTLE_TICKS = 4'h3;
  localparam logic [CNT_W-1:0] SETUP_TICKS = 4'h1;
  localparam logic [CNT_W-1:0] WR_HOLD_TICKS = 4'h1;
  localparam logic [CNT_W-1:0] GAP_FAST_TICKS = 4'h2;
  localparam int GAP_SLOW_NS = 200;
  localparam logic [CNT_W-1:0] GAP_SLOW_TICKS = CNT_W'((GAP_SLOW_NS + BASE_PERIOD_NS - 1) / BASE_PERIOD_NS);
  localparam int REL_STEP_NS = 50;
  localparam logic [CNT_W-1:0] REL_TICKS = CNT_W'(REL_STEP_NS / BASE_PERIOD_NS);
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

  // i/o window decode
  localparam int IOB_HI = 9;
  localparam int IOB_LO = 5;
  localparam int OFS_REG_BIT = 4;
  localparam logic [4:0] OFS_RDP = 5'h10;
  localparam logic [4:0] OFS_RAP = 5'h12;
  localparam logic [4:0] OFS_RESET = 5'h14;
  localparam logic [4:0] OFS_IDP = 5'h16;
  localparam int STA_DEPTH = 16;

  typedef enum logic [3:0] {
    ST_IDLE, ST_IO_WAIT, ST_HOLD, ST_ROM_WAIT, ST_ROM_CS,
    ST_M_REQ, ST_M_SETTLE, ST_M_ADDR, ST_M_CMD, ST_M_WHOLD, ST_M_GAP, ST_M_REL1, ST_M_REL2
  } ibs_state_t;

  typedef struct packed {
    ibs_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [STA_DEPTH-1:0][7:0] sta;
    logic [7:0] hold_byte;
    logic [7:0] register_address_port;
    logic cyc_write;
    logic [15:0] sd;
    logic sd_lo_oe_n;
    logic sd_hi_oe_n;
    logic iochrdy_oe_n;
    logic iocs16_oe_n;
    logic drq;
    logic master_n;
    logic [23:0] addr;
    logic sbhe_n;
    logic addr_oe_n;
    logic memr_n;
    logic memw_n;
    logic cmd_oe_n;
    logic rom_cs_n;
    logic reg_rd;
    logic reg_wr;
    logic reg_sel;
    logic [15:0] reg_wdata;
    logic soft_reset;
    logic xfer_accept;
    logic xfer_done;
    logic [15:0] xfer_rdata;
  } ibs_core_t;

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic tick;
  } ibs_div_t;
endpackage

// ==== ibs_tick_div.sv ====
// divider that makes the 20 mhz base tick from the system clock
`timescale 1ns/10ps
`default_nettype none
module ibs_tick_div (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // one-cycle tick every base period
  output logic tick_out
);
  ibs_pkg::ibs_div_t s_reg;
  ibs_pkg::ibs_div_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (s_reg.cnt == ibs_pkg::DIV_LAST) begin
      s_next.cnt = '0;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + 3'h1;
    end
    if (reset_in) begin
      s_next = '0;
    end
  end

  always_ff @(posedge clock_in) begin
    s_reg <= s_next;
  end

  assign tick_out = s_reg.tick;

  chk_tick_period: assert property (@(posedge clock_in) disable iff (reset_in)
    tick_out |=> !tick_out[*4] ##1 tick_out) else $error("base tick period wrong");
endmodule // ibs_tick_div
`default_nettype wire

// ==== ibs_core.sv ====
// isa slave and bus master interface of the network controller
//
// Overview of operation
// - station address read from loaded, read-only ram
// - 8-bit reads use low lane, odd swapped
// - even byte write held, odd write completes word
// - only data port and boot rom reads pull ready low
// - iocs16 only when 16-bit i/o enabled
// - reset port read resets, station address kept
// - write to reset port is harmless
// - config registers reached via address port
// - boot rom read fetches one byte, in master mode only
// - boot rom select lasts three ticks
// - bus requested only in master mode
// - drq, then master asserted on dack
// - three ticks after master before driving
// - target memory assumed 16-bit, programmed lengths
// - release: commands, then float and drq, then master
// - read: address one tick before memr
// - read data captured, two idle ticks
// - write: address, data one tick early
// - write data held one tick
// - write gap two or four ticks
// - dack ignored while refresh active
`timescale 1ns/10ps
`default_nettype none
module ibs_core (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // configuration
  input wire logic bus_master_mode_in,
  input wire logic io_16bit_in,
  input wire logic fast_recovery_in,
  input wire logic [4:0] io_base_in,
  input wire logic [3:0] master_read_active_len_in,
  input wire logic [3:0] master_write_active_len_in,
  // station address load from serial configuration memory
  input wire logic sta_load_we_in,
  input wire logic [3:0] sta_load_idx_in,
  input wire logic [7:0] sta_load_data_in,
  // isa inputs
  input wire logic aen_in,
  input wire logic [19:0] sa_in,
  input wire logic sbhe_n_in,
  input wire logic ior_n_in,
  input wire logic iow_n_in,
  input wire logic memr_n_in,
  input wire logic ref_n_in,
  input wire logic dack_n_in,
  input wire logic boot_rom_hit_in,
  input wire logic iochrdy_in,
  input wire logic [15:0] sd_in,
  // isa data and open-drain outputs
  output logic [15:0] sd_out,
  output logic sd_lo_oe_n_out,
  output logic sd_hi_oe_n_out,
  output logic iochrdy_out,
  output logic iochrdy_oe_n_out,
  output logic iocs16_out,
  output logic iocs16_oe_n_out,
  // isa master outputs
  output logic drq_out,
  output logic master_n_out,
  output logic [23:0] addr_out,
  output logic sbhe_n_out,
  output logic addr_oe_n_out,
  output logic memr_n_out,
  output logic memw_n_out,
  output logic cmd_oe_n_out,
  // private data bus and boot rom
  input wire logic [7:0] private_data_bus_in,
  output logic boot_rom_select_n_out,
  // internal register port
  input wire logic [15:0] reg_rdata_in,
  input wire logic reg_rdata_valid_in,
  output logic reg_rd_out,
  output logic reg_wr_out,
  output logic reg_sel_out,
  output logic [7:0] reg_index_out,
  output logic [15:0] reg_wdata_out,
  output logic soft_reset_out,
  // master transfer request port
  input wire logic xfer_valid_in,
  input wire logic xfer_write_in,
  input wire logic [23:0] xfer_addr_in,
  input wire logic [15:0] xfer_wdata_in,
  output logic xfer_accept_out,
  output logic xfer_done_out,
  output logic [15:0] xfer_rdata_out
);
  ibs_pkg::ibs_core_t s_reg;
  ibs_pkg::ibs_core_t s_next;
  logic tick;
  logic io_hit;
  logic [4:0] ofs;
  logic is_station;
  logic is_reset;
  logic is_rap;
  logic is_data;
  logic rom_hit;
  logic full;
  logic even;
  logic [7:0] hi_byte;
  logic [15:0] word;
  logic [17:0] ln;
  logic launch;
  logic soft_go;

  ibs_tick_div u_div (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .tick_out(tick)
  );

  function automatic ibs_pkg::ibs_core_t rst_val();
    ibs_pkg::ibs_core_t r;
    r = '0;
    r.st = ibs_pkg::ST_IDLE;
    r.sd_lo_oe_n = 1'b1;
    r.sd_hi_oe_n = 1'b1;
    r.iochrdy_oe_n = 1'b1;
    r.iocs16_oe_n = 1'b1;
    r.master_n = 1'b1;
    r.sbhe_n = 1'b1;
    r.addr_oe_n = 1'b1;
    r.memr_n = 1'b1;
    r.memw_n = 1'b1;
    r.cmd_oe_n = 1'b1;
    r.rom_cs_n = 1'b1;
    return r;
  endfunction

  // lane steering: {lo_oe_n, hi_oe_n, data}
  function automatic logic [17:0] lanes(input logic [15:0] w, input logic narrow, input logic a0,
                                        input logic bhe_n);
    logic [17:0] r;
    r = {1'b0, 1'b1, 8'h00, (a0 ? w[15:8] : w[7:0])};
    if (!narrow) begin
      if (a0) begin
        r = {1'b1, 1'b0, w[15:8], 8'h00};
      end else if (!bhe_n) begin
        r = {1'b0, 1'b0, w};
      end else begin
        r = {1'b0, 1'b1, 8'h00, w[7:0]};
      end
    end
    return r;
  endfunction

  assign ofs = sa_in[4:0];
  assign io_hit = !aen_in && (sa_in[ibs_pkg::IOB_HI:ibs_pkg::IOB_LO] == io_base_in) && (!ior_n_in || !iow_n_in);
  assign is_station = !ofs[ibs_pkg::OFS_REG_BIT];
  assign is_reset = ({ofs[4:1], 1'b0} == ibs_pkg::OFS_RESET);
  assign is_rap = ({ofs[4:1], 1'b0} == ibs_pkg::OFS_RAP);
  assign is_data = ({ofs[4:1], 1'b0} == ibs_pkg::OFS_RDP) || ({ofs[4:1], 1'b0} == ibs_pkg::OFS_IDP);
  assign rom_hit = bus_master_mode_in && boot_rom_hit_in && ref_n_in && !memr_n_in;

  always_comb begin
    s_next = s_reg;
    s_next.reg_rd = 1'b0;
    s_next.reg_wr = 1'b0;
    s_next.soft_reset = 1'b0;
    s_next.xfer_accept = 1'b0;
    s_next.xfer_done = 1'b0;
    launch = 1'b0;
    soft_go = 1'b0;
    // write word assembly for byte-wide and word-wide register writes
    full = io_16bit_in && !sa_in[0] && !sbhe_n_in;
    even = !sa_in[0] && !full;
    hi_byte = io_16bit_in ? sd_in[15:8] : sd_in[7:0];
    word = full ? sd_in : {hi_byte, s_reg.hold_byte};
    ln = lanes(reg_rdata_in, !io_16bit_in, sa_in[0], sbhe_n_in);
    if (sta_load_we_in) begin
      s_next.sta[sta_load_idx_in] = sta_load_data_in;
    end
    unique case (s_reg.st)
      ibs_pkg::ST_IDLE: begin
        if (io_hit) begin
          s_next.iochrdy_oe_n = 1'b0;
          s_next.st = ibs_pkg::ST_HOLD;
          if (is_data || is_rap) begin
            s_next.iocs16_oe_n = !io_16bit_in;
          end
          if (!ior_n_in) begin
            if (is_station) begin
              ln = lanes({2{s_reg.sta[ofs[3:0]]}}, 1'b1, sa_in[0], sbhe_n_in);
              {s_next.sd_lo_oe_n, s_next.sd_hi_oe_n, s_next.sd} = ln;
              s_next.iochrdy_oe_n = 1'b1;
            end else if (is_reset) begin
              soft_go = 1'b1;
            end else if (is_rap) begin
              ln = lanes({8'h00, s_reg.register_address_port}, !io_16bit_in, sa_in[0], sbhe_n_in);
              {s_next.sd_lo_oe_n, s_next.sd_hi_oe_n, s_next.sd} = ln;
              s_next.iochrdy_oe_n = 1'b1;
            end else if (is_data) begin
              s_next.reg_rd = 1'b1;
              s_next.reg_sel = ({ofs[4:1], 1'b0} == ibs_pkg::OFS_IDP);
              s_next.st = ibs_pkg::ST_IO_WAIT;
            end else begin
              s_next.iochrdy_oe_n = 1'b1;
            end
          end else begin
            // station ram is write protected and a reset port write does nothing
            s_next.iochrdy_oe_n = 1'b1;
            if (is_rap || is_data) begin
              if (even) begin
                s_next.hold_byte = sd_in[7:0];
              end else if (is_rap) begin
                s_next.register_address_port = word[7:0];
              end else begin
                s_next.reg_wr = 1'b1;
                s_next.reg_wdata = word;
                s_next.reg_sel = ({ofs[4:1], 1'b0} == ibs_pkg::OFS_IDP);
              end
            end
          end
        end else if (rom_hit) begin
          s_next.iochrdy_oe_n = 1'b0;
          s_next.st = ibs_pkg::ST_ROM_WAIT;
        end else if (bus_master_mode_in && xfer_valid_in) begin
          s_next.drq = 1'b1;
          s_next.st = ibs_pkg::ST_M_REQ;
        end
      end
      ibs_pkg::ST_IO_WAIT: begin
        if (reg_rdata_valid_in) begin
          {s_next.sd_lo_oe_n, s_next.sd_hi_oe_n, s_next.sd} = ln;
          s_next.iochrdy_oe_n = 1'b1;
          s_next.st = ibs_pkg::ST_HOLD;
        end
      end
      ibs_pkg::ST_HOLD: begin
        if (ior_n_in && iow_n_in && memr_n_in) begin
          s_next.sd_lo_oe_n = 1'b1;
          s_next.sd_hi_oe_n = 1'b1;
          s_next.iocs16_oe_n = 1'b1;
          s_next.iochrdy_oe_n = 1'b1;
          s_next.st = ibs_pkg::ST_IDLE;
        end
      end
      ibs_pkg::ST_ROM_WAIT: begin
        if (tick) begin
          s_next.rom_cs_n = 1'b0;
          s_next.cnt = ibs_pkg::ROM_CS_TICKS;
          s_next.st = ibs_pkg::ST_ROM_CS;
        end
      end
      ibs_pkg::ST_ROM_CS: begin
        if (tick) begin
          if (s_reg.cnt == ibs_pkg::CNT_ONE) begin
            s_next.rom_cs_n = 1'b1;
            s_next.sd = {8'h00, private_data_bus_in};
            s_next.sd_lo_oe_n = 1'b0;
            s_next.iochrdy_oe_n = 1'b1;
            s_next.st = ibs_pkg::ST_HOLD;
          end else begin
            s_next.cnt = s_reg.cnt - ibs_pkg::CNT_ONE;
          end
        end
      end
      ibs_pkg::ST_M_REQ: begin
        if (tick && !dack_n_in && ref_n_in) begin
          s_next.master_n = 1'b0;
          s_next.cnt = ibs_pkg::SETTLE_TICKS;
          s_next.st = ibs_pkg::ST_M_SETTLE;
        end
      end
      ibs_pkg::ST_M_SETTLE: begin
        if (tick) begin
          if (s_reg.cnt == ibs_pkg::CNT_ONE) begin
            launch = 1'b1;
          end else begin
            s_next.cnt = s_reg.cnt - ibs_pkg::CNT_ONE;
          end
        end
      end
      ibs_pkg::ST_M_ADDR: begin
        if (tick) begin
          s_next.memr_n = s_reg.cyc_write;
          s_next.memw_n = !s_reg.cyc_write;
          s_next.cnt = s_reg.cyc_write ? master_write_active_len_in : master_read_active_len_in;
          if (s_next.cnt == '0) begin
            s_next.cnt = ibs_pkg::CNT_ONE;
          end
          s_next.st = ibs_pkg::ST_M_CMD;
        end
      end
      ibs_pkg::ST_M_CMD: begin
        if (tick) begin
          if (s_reg.cnt != ibs_pkg::CNT_ONE) begin
            s_next.cnt = s_reg.cnt - ibs_pkg::CNT_ONE;
          end else if (iochrdy_in) begin
            s_next.memr_n = 1'b1;
            s_next.memw_n = 1'b1;
            s_next.xfer_done = 1'b1;
            if (s_reg.cyc_write) begin
              s_next.cnt = ibs_pkg::WR_HOLD_TICKS;
              s_next.st = ibs_pkg::ST_M_WHOLD;
            end else begin
              s_next.xfer_rdata = sd_in;
              s_next.cnt = ibs_pkg::GAP_FAST_TICKS;
              s_next.st = ibs_pkg::ST_M_GAP;
            end
          end
        end
      end
      ibs_pkg::ST_M_WHOLD: begin
        if (tick) begin
          s_next.sd_lo_oe_n = 1'b1;
          s_next.sd_hi_oe_n = 1'b1;
          s_next.cnt = (fast_recovery_in ? ibs_pkg::GAP_FAST_TICKS : ibs_pkg::GAP_SLOW_TICKS)
                       - ibs_pkg::WR_HOLD_TICKS;
          s_next.st = ibs_pkg::ST_M_GAP;
        end
      end
      ibs_pkg::ST_M_GAP: begin
        if (tick) begin
          if (s_reg.cnt == ibs_pkg::CNT_ONE) begin
            launch = 1'b1;
          end else begin
            s_next.cnt = s_reg.cnt - ibs_pkg::CNT_ONE;
          end
        end
      end
      ibs_pkg::ST_M_REL1: begin
        if (tick && s_reg.cnt == ibs_pkg::CNT_ONE) begin
          s_next.addr_oe_n = 1'b1;
          s_next.cmd_oe_n = 1'b1;
          s_next.sd_lo_oe_n = 1'b1;
          s_next.sd_hi_oe_n = 1'b1;
          s_next.drq = 1'b0;
          s_next.cnt = ibs_pkg::REL_TICKS;
          s_next.st = ibs_pkg::ST_M_REL2;
        end
      end
      ibs_pkg::ST_M_REL2: begin
        if (tick && s_reg.cnt == ibs_pkg::CNT_ONE) begin
          s_next.master_n = 1'b1;
          s_next.st = ibs_pkg::ST_IDLE;
        end
      end
      default: begin
        s_next.st = ibs_pkg::ST_IDLE;
      end
    endcase
    if (launch) begin
      s_next.cmd_oe_n = 1'b0;
      if (xfer_valid_in) begin
        s_next.addr = xfer_addr_in;
        s_next.sbhe_n = 1'b0;
        s_next.addr_oe_n = 1'b0;
        s_next.cyc_write = xfer_write_in;
        s_next.sd = xfer_wdata_in;
        s_next.sd_lo_oe_n = !xfer_write_in;
        s_next.sd_hi_oe_n = !xfer_write_in;
        s_next.xfer_accept = 1'b1;
        s_next.cnt = ibs_pkg::SETUP_TICKS;
        s_next.st = ibs_pkg::ST_M_ADDR;
      end else begin
        s_next.cnt = ibs_pkg::REL_TICKS;
        s_next.st = ibs_pkg::ST_M_REL1;
      end
    end
    if (soft_go) begin
      s_next = rst_val();
      s_next.sta = s_reg.sta;
      s_next.soft_reset = 1'b1;
      s_next.st = ibs_pkg::ST_HOLD;
    end
    if (reset_in) begin
      s_next = rst_val();
    end
  end

  always_ff @(posedge clock_in) begin
    s_reg <= s_next;
  end

  assign sd_out = s_reg.sd;
  assign sd_lo_oe_n_out = s_reg.sd_lo_oe_n;
  assign sd_hi_oe_n_out = s_reg.sd_hi_oe_n;
  assign iochrdy_out = s_reg.cyc_write & 1'b0;
  assign iochrdy_oe_n_out = s_reg.iochrdy_oe_n;
  assign iocs16_out = s_reg.cyc_write & 1'b0;
  assign iocs16_oe_n_out = s_reg.iocs16_oe_n;
  assign drq_out = s_reg.drq;
  assign master_n_out = s_reg.master_n;
  assign addr_out = s_reg.addr;
  assign sbhe_n_out = s_reg.sbhe_n;
  assign addr_oe_n_out = s_reg.addr_oe_n;
  assign memr_n_out = s_reg.memr_n;
  assign memw_n_out = s_reg.memw_n;
  assign cmd_oe_n_out = s_reg.cmd_oe_n;
  assign boot_rom_select_n_out = s_reg.rom_cs_n;
  assign reg_rd_out = s_reg.reg_rd;
  assign reg_wr_out = s_reg.reg_wr;
  assign reg_sel_out = s_reg.reg_sel;
  assign reg_index_out = s_reg.register_address_port;
  assign reg_wdata_out = s_reg.reg_wdata;
  assign soft_reset_out = s_reg.soft_reset;
  assign xfer_accept_out = s_reg.xfer_accept;
  assign xfer_done_out = s_reg.xfer_done;
  assign xfer_rdata_out = s_reg.xfer_rdata;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  sequence s_bus_quiet;
    addr_oe_n_out && cmd_oe_n_out && sd_lo_oe_n_out && sd_hi_oe_n_out;
  endsequence
  sequence s_cs_three_ticks;
    !boot_rom_select_n_out[*8] ##1 !boot_rom_select_n_out[*7] ##1 boot_rom_select_n_out;
  endsequence

  chk_master_mode_only: assert property ($rose(drq_out) |-> $past(bus_master_mode_in))
    else $error("bus requested outside master mode");
  chk_master_on_dack: assert property ($fell(master_n_out) |-> $past(!dack_n_in && ref_n_in && drq_out))
    else $error("master asserted without valid dack");
  chk_settle_quiet: assert property ($fell(master_n_out) |-> s_bus_quiet[*8])
    else $error("bus driven too soon after master");
  chk_rom_cs_width: assert property ($fell(boot_rom_select_n_out) |-> s_cs_three_ticks)
    else $error("boot rom select not three ticks");
  chk_high_lane_use: assert property (!sd_hi_oe_n_out |-> io_16bit_in || !master_n_out)
    else $error("high lane driven in byte mode");
  chk_iocs16_gate: assert property (!iocs16_oe_n_out |-> io_16bit_in)
    else $error("iocs16 driven while disabled");
  chk_byte_pair_word: assert property (reg_wr_out && !io_16bit_in |-> reg_wdata_out[15:8] == $past(sd_in[7:0]))
    else $error("odd byte not placed in upper half");
  chk_release_order: assert property ($fell(drq_out) && !master_n_out |-> !master_n_out[*5] ##1 master_n_out)
    else $error("master not dropped one tick after drq");
  chk_read_setup: assert property ($fell(memr_n_out) |-> $past(!addr_oe_n_out, 5))
    else $error("address not set up before memr");
  chk_write_hold: assert property ($rose(memw_n_out) |-> !sd_lo_oe_n_out[*5])
    else $error("write data not held one tick");
  chk_read_gap: assert property ($rose(memr_n_out) |-> (memr_n_out && memw_n_out)[*8])
    else $error("command recovery too short");
  chk_ready_pull: assert property (s_reg.st == ibs_pkg::ST_IDLE && io_hit && !is_reset && !ior_n_in && is_data
                                   |=> !iochrdy_oe_n_out)
    else $error("ready not pulled low on register read");
endmodule // ibs_core
`default_nettype wire

// ==== ibs_host_model.sv ====
// isa host side model: dma grant, ready and 16-bit memory
`timescale 1ns/10ps
`default_nettype none
module ibs_host_model (
  // clock and device side
  input wire logic clock_in,
  input wire logic drq_in,
  input wire logic memr_n_in,
  input wire logic memw_n_in,
  input wire logic [23:0] addr_in,
  input wire logic [15:0] sd_in,
  input wire logic slow_in,
  // grant, ready and data
  output logic dack_n_out,
  output logic iochrdy_out,
  output logic [15:0] sd_out
);
  logic [15:0] mem [16];
  logic [15:0] last = 16'h0000;
  logic [2:0] wt = 3'h0;
  logic dk = 1'b1;
  logic idle = 1'b1;
  wire logic [3:0] ix = addr_in[4:1];
  always @(posedge clock_in) begin
    dk <= !drq_in;
    idle <= memr_n_in & memw_n_in;
    if (idle && !(memr_n_in & memw_n_in)) wt <= slow_in ? 3'h7 : 3'h0;
    else if (wt != 3'h0) wt <= wt - 3'h1;
    if (!memw_n_in) mem[ix] <= sd_in;
    if (!memr_n_in) last <= mem[ix];
  end
  assign dack_n_out = dk;
  assign iochrdy_out = wt == 3'h0;
  assign sd_out = memr_n_in ? ~last : mem[ix];
endmodule // ibs_host_model
`default_nettype wire

// ==== test_ibs_core.sv ====
// bench of the isa bus interface with its host model
`timescale 1ns/10ps
`default_nettype none
module test_ibs_core;
  logic clock_in = 1'b0, reset_in = 1'b1, mm = 1'b0, w16 = 1'b0, fast = 1'b1, we = 1'b0, aen = 1'b1;
  logic sbhe_n = 1'b1, ior_n = 1'b1, iow_n = 1'b1, memr_n = 1'b1, ref_n = 1'b1, hit = 1'b0, rv = 1'b0;
  logic xv = 1'b0, xw = 1'b0, slow = 1'b0;
  logic [3:0] idx = 4'h0, rlen = 4'h5, wlen = 4'h5;
  logic [7:0] ld = 8'h00, pdb = 8'h00;
  logic [15:0] tsd = 16'h0000, rdat = 16'h0000, xwd = 16'h0000, lw = 16'h0000;
  logic [19:0] sa = 20'h00000;
  logic [23:0] xa = 24'h000000;
  logic [2:0] ln;
  wire logic [15:0] sdo, wd, xrd, msd;
  wire logic lo_n, hi_n, rdy_n, c16_n, drq, mst_n, register_data_port, wrp, sel, srst, acc, done, rom_n, dk_n, mrdy, mr_n, mw_n;
  wire logic sbh_n, ao_n, co_n, rd0, cs0;
  wire logic [7:0] ri;
  wire logic [23:0] ad;
  int error_cnt = 0, compares = 0, nw = 0, ns = 0, rl = 0, cl = 0, c0 = 0, n;
  ibs_core ibs_core_i (.clock_in, .reset_in, .bus_master_mode_in(mm), .io_16bit_in(w16), .fast_recovery_in(fast),
    .io_base_in(5'h0a), .master_read_active_len_in(rlen), .master_write_active_len_in(wlen), .sta_load_we_in(we),
    .sta_load_idx_in(idx), .sta_load_data_in(ld), .aen_in(aen), .sa_in(sa), .sbhe_n_in(sbhe_n), .ior_n_in(ior_n),
    .iow_n_in(iow_n), .memr_n_in(memr_n), .ref_n_in(ref_n), .dack_n_in(dk_n), .boot_rom_hit_in(hit),
    .iochrdy_in(mrdy & rdy_n), .sd_in(!mst_n ? msd : tsd), .sd_out(sdo), .sd_lo_oe_n_out(lo_n),
    .sd_hi_oe_n_out(hi_n), .iochrdy_out(rd0), .iochrdy_oe_n_out(rdy_n), .iocs16_out(cs0), .iocs16_oe_n_out(c16_n),
    .drq_out(drq), .master_n_out(mst_n), .addr_out(ad), .sbhe_n_out(sbh_n), .addr_oe_n_out(ao_n), .memr_n_out(mr_n),
    .memw_n_out(mw_n), .cmd_oe_n_out(co_n), .private_data_bus_in(pdb), .boot_rom_select_n_out(rom_n),
    .reg_rdata_in(rdat), .reg_rdata_valid_in(rv), .reg_rd_out(register_data_port), .reg_wr_out(wrp), .reg_sel_out(sel),
    .reg_index_out(ri), .reg_wdata_out(wd), .soft_reset_out(srst), .xfer_valid_in(xv), .xfer_write_in(xw),
    .xfer_addr_in(xa), .xfer_wdata_in(xwd), .xfer_accept_out(acc), .xfer_done_out(done), .xfer_rdata_out(xrd));
  ibs_host_model ibs_host_model_i (.clock_in, .drq_in(drq), .memr_n_in(mr_n), .memw_n_in(mw_n), .addr_in(ad),
    .sd_in(sdo), .slow_in(slow), .dack_n_out(dk_n), .iochrdy_out(mrdy), .sd_out(msd));
  initial forever #5 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    if (wrp === 1'b1) begin
      nw <= nw + 1;
      lw <= wd;
    end
    if (srst === 1'b1) ns <= ns + 1;
    if (rom_n === 1'b0) rl <= rl + 1;
    if (!(mr_n & mw_n)) cl <= cl + 1;
    rv <= (register_data_port === 1'b1) | (rv & !ior_n);
  end
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    if (error_cnt == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic guard;
    if (n >= 300) begin
      error_cnt++;
      report_and_stop();
    end
  endtask
  task automatic io(input bit wr, input logic [4:0] o, input logic [15:0] d, output logic [15:0] g);
    @(posedge clock_in);
    {aen, sa, sbhe_n, tsd} <= {1'b0, 10'h000, 5'h0a, o, !w16 & !o[0], d};
    {ior_n, iow_n} <= {wr, !wr};
    repeat (3) @(negedge clock_in);
    for (n = 0; n < 300 && rdy_n !== 1'b1; n++) @(negedge clock_in);
    guard();
    g = sdo;
    ln = {hi_n, lo_n, c16_n};
    chk({rd0, cs0}, 2'b00);
    @(posedge clock_in);
    {ior_n, iow_n, aen} <= 3'b111;
    repeat (2) @(posedge clock_in);
  endtask
  task automatic xfer(input bit wr, input logic [23:0] a, input logic [15:0] d, output logic [15:0] g);
    @(posedge clock_in);
    {xv, xw, xa, xwd} <= {1'b1, wr, a, d};
    c0 = cl;
    for (n = 0; n < 300 && acc !== 1'b1; n++) @(negedge clock_in);
    guard();
    chk(ad, a);
    chk({sbh_n, ao_n, co_n, mr_n, mw_n, lo_n, hi_n}, {5'b00011, !wr, !wr});
    @(posedge clock_in);
    xv <= 1'b0;
    for (n = 0; n < 300 && done !== 1'b1; n++) @(negedge clock_in);
    guard();
    g = xrd;
  endtask
  initial begin
    logic [7:0] st [16];
    logic [15:0] g, v;
    int s;
    void'($urandom(1166));
    repeat (8) @(posedge clock_in);
    reset_in <= 1'b0;
    @(negedge clock_in);
    chk({drq, mst_n, lo_n, hi_n, rdy_n, c16_n, rom_n}, 7'h3f);
    for (int i = 0; i < 16; i++) begin
      st[i] = 8'($urandom);
      @(posedge clock_in);
      {we, idx, ld} <= {1'b1, 4'(i), st[i]};
    end
    @(posedge clock_in);
    we <= 1'b0;
    io(1'b1, 5'h03, 16'h5aa5, g);
    for (int i = 0; i < 16; i++) begin
      io(1'b0, 5'(i), 16'h0000, g);
      chk({ln[2:1], g[7:0]}, {2'b10, st[i]});
    end
    chk(nw, 0);
    for (int m = 0; m < 2; m++) begin
      v = 16'($urandom);
      @(posedge clock_in);
      {w16, rdat} <= {1'(m), v};
      io(1'b0, m ? 5'h10 : 5'h11, 16'h0000, g);
      chk({ln, m ? g : {8'h00, g[7:0]}}, {m ? 3'b000 : 3'b101, m ? v : {8'h00, v[15:8]}});
    end
    v = 16'($urandom);
    io(1'b1, 5'h12, v, g);
    chk(ri, v[7:0]);
    @(posedge clock_in);
    rdat <= ~v;
    io(1'b0, 5'h16, 16'h0000, g);
    chk({sel, ln, g}, {1'b1, 3'b000, ~v});
    s = ns;
    io(1'b0, 5'h14, 16'h0000, g);
    chk({4'(ns - s), ln[0], ri}, {4'h1, 1'b1, 8'h00});
    s = nw + ns;
    io(1'b1, 5'h14, 16'hffff, g);
    chk({4'(nw + ns - s), ri}, 12'h000);
    @(posedge clock_in);
    w16 <= 1'b0;
    v = 16'($urandom);
    s = nw;
    io(1'b1, 5'h10, {2{v[7:0]}}, g);
    io(1'b1, 5'h11, {2{v[15:8]}}, g);
    chk({4'(nw - s), lw}, {4'h1, v});
    @(posedge clock_in);
    {xv, xw} <= 2'b11;
    s = 0;
    repeat (40) begin
      @(negedge clock_in);
      s += (drq !== 1'b0);
    end
    chk(s, 0);
    @(posedge clock_in);
    {mm, ref_n} <= 2'b10;
    repeat (40) @(negedge clock_in);
    chk({drq, mst_n}, 2'b11);
    @(posedge clock_in);
    ref_n <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      v = 16'($urandom);
      @(posedge clock_in);
      {fast, slow, wlen, rlen} <= {1'(k), 1'(k >> 1), 4'(1 + $urandom % 5), 4'(1 + $urandom % 5)};
      xfer(1'b1, {19'($urandom), 4'(k), 1'b0}, v, g);
      if (!slow) chk(cl - c0, 5 * wlen);
      xfer(1'b0, {19'($urandom), 4'(k), 1'b0}, 16'h0000, g);
      chk(g, v);
      if (!slow) chk(cl - c0, 5 * rlen);
    end
    for (n = 0; n < 300 && mst_n !== 1'b1; n++) @(negedge clock_in);
    guard();
    v = 16'($urandom);
    @(posedge clock_in);
    {pdb, hit, memr_n} <= {v[7:0], 2'b10};
    s = rl;
    repeat (3) @(negedge clock_in);
    for (n = 0; n < 300 && rdy_n !== 1'b1; n++) @(negedge clock_in);
    guard();
    chk({lo_n, hi_n, sdo[7:0]}, {2'b01, v[7:0]});
    chk(rl - s, 15);
    @(posedge clock_in);
    {hit, memr_n} <= 2'b01;
    repeat (4) @(posedge clock_in);
    report_and_stop();
  end
endmodule // test_ibs_core
`default_nettype wire
